// ### core/owd_pkg.sv
// constants, codes and state type for the one-wire debug link line layer
package owd_pkg;
  // =====================================================
  // clocking
  localparam int REF_CLK_MHZ = 40;
  localparam int LINK_MHZ_16 = 16;
  localparam int LINK_MHZ_8 = 8;
  localparam int LINK_MHZ_4 = 4;
  localparam logic [1:0] CLKSEL_16 = 2'h1;
  localparam logic [1:0] CLKSEL_8 = 2'h2;
  localparam logic [1:0] CLKSEL_4 = 2'h3;
  localparam logic [1:0] CLKSEL_DFLT = CLKSEL_4;
  // =====================================================
  // register map
  localparam logic [3:0] OFS_LINK_CONTROL_A = 4'h0;
  localparam logic [3:0] OFS_ASYNC_IF_CONTROL_A = 4'h1;
  localparam logic [3:0] OFS_ERROR_STATUS = 4'h2;
  localparam logic [3:0] OFS_LINK_STATE = 4'h3;
  localparam logic [3:0] OFS_SYSTEM_INFO = 4'h4;
  localparam int BIT_PARITY_DISABLE = 0;
  localparam int BIT_STATE_ACTIVE = 0;
  localparam int BIT_STATE_SYNCED = 1;
  localparam int BIT_STATE_ERROR = 2;
  localparam int BIT_STATE_PRIV = 3;
  localparam logic PARITY_DISABLE_RST = 1'b0;
  // =====================================================
  // frame
  localparam int BREAK_BITS = 12;
  localparam int IDLE_BITS = 12;
  localparam logic [3:0] FRAME_LAST_IDX = 4'hB;
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam logic [2:0] SYNC_FALLS = 3'h4;
  localparam logic [12:0] PERIOD_DFLT = 13'h1FFF;
  localparam logic [12:0] PERIOD_MIN = 13'h0004;
  localparam logic [7:0] ACK_CODE = 8'h40;
  // =====================================================
  // error signature codes and sticky flag positions
  localparam logic [2:0] SIG_NONE = 3'h0;
  localparam logic [2:0] SIG_PARITY = 3'h1;
  localparam logic [2:0] SIG_CLOCK = 3'h2;
  localparam logic [2:0] SIG_FRAME = 3'h3;
  localparam logic [2:0] SIG_SYSTEM = 3'h4;
  localparam int ERR_PARITY = 0;
  localparam int ERR_CLOCK = 1;
  localparam int ERR_FRAME = 2;
  localparam int ERR_SYSTEM = 3;
  // =====================================================
  // line layer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_SYNC,
    ST_MEAS,
    ST_IDLE,
    ST_RX,
    ST_TX,
    ST_BUS_WAIT,
    ST_ERROR
  } owd_state_t;
endpackage

// ### core/owd_sync.sv
// two-flop synchronisers for the pin-side inputs
`timescale 1ns/1ps
`default_nettype none
module owd_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);
  // =====================================================
  // one pair of flops per bit
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_bit
      logic meta; // first stage, read only by second stage
      logic held; // second stage
      // metastability filter
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta <= 1'b0;
          held <= 1'b0;
        end
        else
        begin
          meta <= async_in[gi];
          held <= meta;
        end
      end
      assign sync_out[gi] = held;
    end
  endgenerate
endmodule
`default_nettype wire

// ### core/owd_tick_gen.sv
// fractional tick generator standing in for the link oscillator
`timescale 1ns/1ps
`default_nettype none
module owd_tick_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] sel,
  output logic tick
);
  // =====================================================
  // step size per selected rate
  logic [5:0] acc; // phase, modulo reference rate
  logic [5:0] step; // link rate in MHz
  logic [6:0] sum; // one bit wider to see the wrap
  // divider codes, reserved code falls back to slowest
  always_comb
  begin
    unique case (sel)
      owd_pkg::CLKSEL_16: step = 6'(owd_pkg::LINK_MHZ_16);
      owd_pkg::CLKSEL_8: step = 6'(owd_pkg::LINK_MHZ_8);
      owd_pkg::CLKSEL_4: step = 6'(owd_pkg::LINK_MHZ_4);
      default: step = 6'(owd_pkg::LINK_MHZ_4);
    endcase
  end
  assign sum = {1'b0, acc} + {1'b0, step};
  // =====================================================
  // accumulate; average tick rate is exact, jitter one cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc <= 6'h00;
      tick <= 1'b0;
    end
    else if (sum >= 7'(owd_pkg::REF_CLK_MHZ))
    begin
      acc <= 6'(sum - 7'(owd_pkg::REF_CLK_MHZ));
      tick <= 1'b1;
    end
    else
    begin
      acc <= sum[5:0];
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### core/owd_link_phy.sv
// line layer of the one-wire debug link: framing, baud recovery, break, ack
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module owd_link_phy (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic RST_PIN_FUSE,
  input wire logic HV_ENABLE,
  input wire logic LINK_PIN_IN,
  output logic LINK_PIN_OUT,
  output logic LINK_PIN_OE_N,
  output logic LINK_PULL_EN,
  output logic LINK_IN_EN,
  output logic [7:0] RX_BYTE,
  output logic RX_STROBE,
  input wire logic [7:0] TX_BYTE,
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic EXPECT_SYNC,
  input wire logic STORE_REQ,
  output logic BUS_REQ,
  input wire logic BUS_GRANT,
  output logic LINK_BREAK,
  input wire logic KEY_MATCH,
  input wire logic MODE_OK,
  output logic PRIV_ACCESS_EN,
  input wire logic [7:0] SYSTEM_INFO
);
  // =====================================================
  // pin inputs and link tick
  logic [2:0] raw_in; // pin-side levels
  logic [2:0] sync_in; // after two flops
  logic pin_s; // synced line level
  logic active; // link owns the pin
  logic tick; // one link oscillator period
  assign raw_in = {HV_ENABLE, RST_PIN_FUSE, LINK_PIN_IN};
  owd_sync u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .async_in(raw_in),
    .sync_out(sync_in)
  );
  assign pin_s = sync_in[0];
  assign active = sync_in[1] | sync_in[2];
  logic [1:0] clksel; // divider select field
  owd_tick_gen u_tick (
    .clk(REF_CLK),
    .rst(RST),
    .sel(clksel),
    .tick(tick)
  );
  // =====================================================
  // state and datapath registers
  owd_pkg::owd_state_t state;
  owd_pkg::owd_state_t next_state;
  logic parity_check_disable; // parity check disable
  logic [3:0] err_flags; // sticky error classes
  logic [2:0] err_sig; // last error signature
  logic active_d; // for enable edge
  logic pin_d; // previous line level
  logic [16:0] low_cnt; // ticks of continuous low
  logic [12:0] period; // recovered bit period in ticks
  logic [15:0] meas_cnt; // synch measurement
  logic [2:0] edge_cnt; // falls seen inside synch
  logic [12:0] bit_tmr; // ticks inside current bit
  logic [3:0] bit_idx; // bit number in frame
  logic [10:0] rx_sr; // received bits after start
  logic [11:0] tx_sr; // outgoing frame, lsb on line
  logic synced; // period valid
  // =====================================================
  // events
  logic fall; // line fell
  logic [16:0] brk_limit; // ticks that make a break
  logic brk_hit; // break recognised
  logic [12:0] half_period; // centre offset
  logic [12:0] bit_target; // tick count ending a bit
  logic bit_end; // bit boundary or sample point
  logic mid_bit; // centre of transmitted bit
  logic [10:0] rx_fin; // completed frame bits
  logic rx_last; // last sample of frame
  logic start_bad; // start bit was a glitch
  logic par_err; // parity mismatch
  logic frm_err; // stop bit mismatch
  logic contend; // line not what we drive
  logic meas_ovf; // synch too slow
  logic meas_done; // last synch fall seen
  logic [12:0] meas_period; // eight bits divided by eight
  logic clk_err; // synch outside usable range
  logic tx_take; // data byte accepted
  assign fall = pin_d & ~pin_s;
  assign brk_limit = 17'({4'h0, period} * 17'(owd_pkg::BREAK_BITS));
  // runs in every state so a break always gets through
  assign brk_hit = active && tick && !pin_s && ((low_cnt + 17'h00001) == brk_limit);
  assign half_period = {1'b0, period[12:1]};
  // first sample lands half a bit after the start edge
  assign bit_target = (state == owd_pkg::ST_RX && bit_idx == 4'h0) ? half_period : period - 13'h0001;
  assign bit_end = tick && (bit_tmr == bit_target);
  assign mid_bit = tick && (bit_tmr == half_period);
  assign rx_fin = {pin_s, rx_sr[10:1]};
  assign rx_last = (state == owd_pkg::ST_RX) && bit_end && (bit_idx == owd_pkg::FRAME_LAST_IDX);
  assign start_bad = (state == owd_pkg::ST_RX) && bit_end && (bit_idx == 4'h0) && pin_s;
  assign par_err = rx_last && !parity_check_disable && (rx_fin[8] != ^rx_fin[7:0]);
  assign frm_err = rx_last && !(rx_fin[9] & rx_fin[10]);
  assign contend = (state == owd_pkg::ST_TX) && mid_bit && (pin_s != tx_sr[0]);
  assign meas_ovf = (state == owd_pkg::ST_MEAS) && (meas_cnt == 16'hFFFF);
  // alternating pattern: four more falls span eight bit times
  assign meas_done = (state == owd_pkg::ST_MEAS) && fall && ((edge_cnt + 3'h1) == owd_pkg::SYNC_FALLS);
  assign meas_period = meas_cnt[15:3];
  assign clk_err = meas_ovf || (meas_done && (meas_period < owd_pkg::PERIOD_MIN));
  assign tx_take = (state == owd_pkg::ST_IDLE) && TX_VALID && !EXPECT_SYNC && !fall && !STORE_REQ;
  // =====================================================
  // next state
  always_comb
  begin
    next_state = state;
    if (!active)
    begin
      next_state = owd_pkg::ST_OFF;
    end
    else if (brk_hit)
    begin
      next_state = owd_pkg::ST_WAIT_SYNC;
    end
    else
    begin
      unique case (state)
        owd_pkg::ST_OFF: next_state = owd_pkg::ST_WAIT_SYNC;
        owd_pkg::ST_WAIT_SYNC:
        begin
          if (fall)
            next_state = owd_pkg::ST_MEAS;
        end
        owd_pkg::ST_MEAS:
        begin
          if (clk_err)
            next_state = owd_pkg::ST_ERROR;
          else if (meas_done)
            next_state = owd_pkg::ST_IDLE;
        end
        owd_pkg::ST_IDLE:
        begin
          // new instruction must open with a synch
          if (EXPECT_SYNC)
            next_state = owd_pkg::ST_WAIT_SYNC;
          else if (fall)
            next_state = owd_pkg::ST_RX;
          else if (STORE_REQ)
            next_state = owd_pkg::ST_BUS_WAIT;
          else if (TX_VALID)
            next_state = owd_pkg::ST_TX;
        end
        owd_pkg::ST_RX:
        begin
          if (start_bad)
            next_state = owd_pkg::ST_IDLE;
          else if (par_err || frm_err)
            next_state = owd_pkg::ST_ERROR;
          else if (rx_last)
            next_state = owd_pkg::ST_IDLE;
        end
        owd_pkg::ST_TX:
        begin
          if (contend)
            next_state = owd_pkg::ST_ERROR;
          else if (bit_end && bit_idx == owd_pkg::FRAME_LAST_IDX)
            next_state = owd_pkg::ST_IDLE;
        end
        owd_pkg::ST_BUS_WAIT:
        begin
          // host stays quiet until the ack, so no receive here
          if (BUS_GRANT)
            next_state = owd_pkg::ST_TX;
        end
        owd_pkg::ST_ERROR: next_state = owd_pkg::ST_ERROR;
      endcase
    end
  end
  // state register
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      state <= owd_pkg::ST_OFF;
    else
      state <= next_state;
  end
  // =====================================================
  // line level history and break counter
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      pin_d <= 1'b0;
      active_d <= 1'b0;
      low_cnt <= 17'h00000;
    end
    else
    begin
      pin_d <= pin_s;
      active_d <= active;
      if (pin_s || !active)
        low_cnt <= 17'h00000;
      else if (tick && low_cnt != 17'h1FFFF)
        low_cnt <= low_cnt + 17'h00001;
    end
  end
  // =====================================================
  // baud recovery from the synch character
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      period <= owd_pkg::PERIOD_DFLT;
      synced <= 1'b0;
      meas_cnt <= 16'h0000;
      edge_cnt <= 3'h0;
    end
    else if (!active || brk_hit)
    begin
      // default slow period keeps break length safe
      period <= owd_pkg::PERIOD_DFLT;
      synced <= 1'b0;
      meas_cnt <= 16'h0000;
      edge_cnt <= 3'h0;
    end
    else if (state == owd_pkg::ST_WAIT_SYNC)
    begin
      meas_cnt <= 16'h0000;
      edge_cnt <= 3'h0;
    end
    else if (state == owd_pkg::ST_MEAS)
    begin
      if (meas_done && !clk_err)
      begin
        period <= meas_period;
        synced <= 1'b1;
      end
      if (tick && !meas_ovf)
        meas_cnt <= meas_cnt + 16'h0001;
      if (fall)
        edge_cnt <= edge_cnt + 3'h1;
    end
  end
  // =====================================================
  // bit timer shared by receive and transmit
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      bit_tmr <= 13'h0000;
      bit_idx <= 4'h0;
    end
    else if (state != next_state)
    begin
      bit_tmr <= 13'h0000;
      bit_idx <= 4'h0;
    end
    else if (bit_end)
    begin
      bit_tmr <= 13'h0000;
      bit_idx <= bit_idx + 4'h1;
    end
    else if (tick)
    begin
      bit_tmr <= bit_tmr + 13'h0001;
    end
  end
  // =====================================================
  // receive shift and byte hand-off
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      rx_sr <= 11'h000;
      RX_BYTE <= 8'h00;
      RX_STROBE <= 1'b0;
    end
    else
    begin
      // first bit in ends at bit 0 of the byte
      if (state == owd_pkg::ST_RX && bit_end && bit_idx != 4'h0)
        rx_sr <= rx_fin;
      RX_STROBE <= rx_last && !par_err && !frm_err;
      if (rx_last && !par_err && !frm_err)
        RX_BYTE <= rx_fin[7:0];
    end
  end
  // =====================================================
  // transmit frame: start, data, even parity, two stops
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      tx_sr <= 12'hFFF;
    end
    else if (tx_take)
    begin
      tx_sr <= {2'b11, ^TX_BYTE, TX_BYTE, 1'b0};
    end
    else if (state == owd_pkg::ST_BUS_WAIT && BUS_GRANT)
    begin
      tx_sr <= {2'b11, ^owd_pkg::ACK_CODE, owd_pkg::ACK_CODE, 1'b0};
    end
    else if (state == owd_pkg::ST_TX && bit_end)
    begin
      tx_sr <= {1'b1, tx_sr[11:1]};
    end
  end
  // =====================================================
  // pin control, only the transmitter drives
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      LINK_PIN_OUT <= 1'b1;
      LINK_PIN_OE_N <= 1'b1;
      LINK_PULL_EN <= 1'b0;
      LINK_IN_EN <= 1'b0;
    end
    else
    begin
      LINK_PIN_OUT <= (state == owd_pkg::ST_TX) ? tx_sr[0] : 1'b1;
      LINK_PIN_OE_N <= !(active && state == owd_pkg::ST_TX);
      LINK_PULL_EN <= active;
      LINK_IN_EN <= active;
    end
  end
  // =====================================================
  // handshake and status outputs
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      TX_READY <= 1'b0;
      BUS_REQ <= 1'b0;
      LINK_BREAK <= 1'b0;
      PRIV_ACCESS_EN <= 1'b0;
    end
    else
    begin
      TX_READY <= (next_state == owd_pkg::ST_IDLE);
      BUS_REQ <= (next_state == owd_pkg::ST_BUS_WAIT);
      LINK_BREAK <= brk_hit;
      PRIV_ACCESS_EN <= active && KEY_MATCH && MODE_OK;
    end
  end
  // =====================================================
  // error flags and signature, a new error beats a clear
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      err_flags <= 4'h0;
      err_sig <= owd_pkg::SIG_NONE;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (REG_WR && REG_ADDR == owd_pkg::OFS_ERROR_STATUS && REG_WDATA[i])
          err_flags[i] <= 1'b0;
      end
      if (par_err)
        err_flags[owd_pkg::ERR_PARITY] <= 1'b1;
      if (clk_err)
        err_flags[owd_pkg::ERR_CLOCK] <= 1'b1;
      if (frm_err)
        err_flags[owd_pkg::ERR_FRAME] <= 1'b1;
      if (contend)
        err_flags[owd_pkg::ERR_SYSTEM] <= 1'b1;
      // framing outranks parity when both hit
      if (frm_err)
        err_sig <= owd_pkg::SIG_FRAME;
      else if (par_err)
        err_sig <= owd_pkg::SIG_PARITY;
      else if (clk_err)
        err_sig <= owd_pkg::SIG_CLOCK;
      else if (contend)
        err_sig <= owd_pkg::SIG_SYSTEM;
    end
  end
  // =====================================================
  // control registers
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      parity_check_disable <= owd_pkg::PARITY_DISABLE_RST;
      clksel <= owd_pkg::CLKSEL_DFLT;
    end
    else
    begin
      if (REG_WR && REG_ADDR == owd_pkg::OFS_LINK_CONTROL_A)
        parity_check_disable <= REG_WDATA[owd_pkg::BIT_PARITY_DISABLE];
      // enable and break both restore the slow default
      if (brk_hit || (active && !active_d))
        clksel <= owd_pkg::CLKSEL_DFLT;
      else if (REG_WR && REG_ADDR == owd_pkg::OFS_ASYNC_IF_CONTROL_A)
        clksel <= REG_WDATA[1:0];
    end
  end
  // =====================================================
  // read port, data only in the cycle after the strobe
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      REG_RDATA <= 8'h00;
    end
    else if (REG_RD)
    begin
      unique case (REG_ADDR)
        owd_pkg::OFS_LINK_CONTROL_A: REG_RDATA <= {7'h00, parity_check_disable};
        owd_pkg::OFS_ASYNC_IF_CONTROL_A: REG_RDATA <= {6'h00, clksel};
        owd_pkg::OFS_ERROR_STATUS: REG_RDATA <= {1'b0, err_sig, err_flags};
        owd_pkg::OFS_LINK_STATE: REG_RDATA <= {4'h0, PRIV_ACCESS_EN, state == owd_pkg::ST_ERROR, synced, active};
        owd_pkg::OFS_SYSTEM_INFO: REG_RDATA <= SYSTEM_INFO;
        default: REG_RDATA <= 8'h00;
      endcase
    end
    else
    begin
      REG_RDATA <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### sim/owd_link_phy_properties.sv
// port checker for the line layer
`timescale 1ns/1ps
`default_nettype none
module owd_link_phy_checker (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic LINK_PIN_IN,
  input wire logic LINK_PIN_OUT,
  input wire logic LINK_PIN_OE_N,
  input wire logic LINK_PULL_EN,
  input wire logic LINK_IN_EN,
  input wire logic RX_STROBE,
  input wire logic TX_READY,
  input wire logic BUS_REQ,
  input wire logic BUS_GRANT,
  input wire logic LINK_BREAK,
  input wire logic KEY_MATCH,
  input wire logic MODE_OK,
  input wire logic PRIV_ACCESS_EN
);
  // ==========
  // pin ownership and framing
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  // enable lags the state by one cycle, ready does not, so compare with ready one cycle back
  property p_drive_busy; !LINK_PIN_OE_N |-> !$past(TX_READY); endproperty
  a_drive_busy: assert property (p_drive_busy) else $error("pin driven while ready");
  property p_idle_high; LINK_PIN_OE_N |-> LINK_PIN_OUT; endproperty
  a_idle_high: assert property (p_idle_high) else $error("released pin not high");
  property p_start_low; $fell(LINK_PIN_OE_N) |-> !LINK_PIN_OUT; endproperty
  a_start_low: assert property (p_start_low) else $error("frame not opened by low bit");
  property p_pins_off; !LINK_IN_EN |-> LINK_PIN_OE_N && !LINK_PULL_EN; endproperty
  a_pins_off: assert property (p_pins_off) else $error("pin touched while inactive");
  // ==========
  // acknowledge, break and privilege
  property p_ack_go; BUS_REQ && BUS_GRANT |=> !BUS_REQ ##1 !LINK_PIN_OE_N; endproperty
  a_ack_go: assert property (p_ack_go) else $error("no ack frame after grant");
  property p_brk_low; LINK_BREAK |-> !$past(LINK_PIN_IN, 3) && !$past(LINK_PIN_IN, 4); endproperty
  a_brk_low: assert property (p_brk_low) else $error("break without low line");
  property p_brk_abort; LINK_BREAK |-> ##2 (!TX_READY && !BUS_REQ); endproperty
  a_brk_abort: assert property (p_brk_abort) else $error("break left work running");
  property p_priv; PRIV_ACCESS_EN |-> $past(KEY_MATCH && MODE_OK); endproperty
  a_priv: assert property (p_priv) else $error("privilege without key and mode");
  // main scenarios reached
  c_rx: cover property (RX_STROBE);
  c_brk: cover property (LINK_BREAK);
  c_ack: cover property (BUS_REQ && BUS_GRANT);
endmodule
bind owd_link_phy owd_link_phy_checker chk_u (.REF_CLK(REF_CLK), .RST(RST), .LINK_PIN_IN(LINK_PIN_IN),
  .LINK_PIN_OUT(LINK_PIN_OUT), .LINK_PIN_OE_N(LINK_PIN_OE_N), .LINK_PULL_EN(LINK_PULL_EN),
  .LINK_IN_EN(LINK_IN_EN), .RX_STROBE(RX_STROBE), .TX_READY(TX_READY), .BUS_REQ(BUS_REQ),
  .BUS_GRANT(BUS_GRANT), .LINK_BREAK(LINK_BREAK), .KEY_MATCH(KEY_MATCH), .MODE_OK(MODE_OK),
  .PRIV_ACCESS_EN(PRIV_ACCESS_EN));
`default_nettype wire

// ### sim/owd_host_model.sv
// host adapter model: sends and receives frames on the shared line
`timescale 1ns/1ps
`default_nettype none
module owd_host_model #(parameter int BIT = 80) (
  input wire logic clk,
  input wire logic line,
  output logic drv_en,
  output logic drv_bit
);
  // released at start, the pull-up holds the line high
  initial
  begin
    drv_en = 1'h0;
    drv_bit = 1'h1;
  end
  // one frame, start low, lsb first, parity flipped on request
  task automatic send(input logic [7:0] d, input logic bad);
    logic [11:0] f;
    f = {2'h3, ^d ^ bad, d, 1'h0};
    for (int i = 0; i < 12; i++)
    begin
      drv_en <= 1'h1;
      drv_bit <= f[i];
      repeat (BIT) @(posedge clk);
    end
    drv_en <= 1'h0;
    // one released cycle so a following frame never reassigns in this step
    @(posedge clk);
  endtask
  // hold the line low for n cycles
  task automatic brk(input int n);
    drv_en <= 1'h1;
    drv_bit <= 1'h0;
    repeat (n) @(posedge clk);
    drv_en <= 1'h0;
  endtask
  // sample a device frame at bit centres; bounded wait for the start
  task automatic recv(output logic [7:0] d, output logic ok);
    logic [11:0] f;
    for (int i = 0; i < 20000 && line; i++) @(posedge clk);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 12; i++)
    begin
      f[i] = line;
      repeat (BIT) @(posedge clk);
    end
    d = f[8:1];
    ok = !f[0] && !(^f[9:1]) && (&f[11:10]);
  endtask
endmodule
`default_nettype wire

// ### sim/tb_one_wire_debug_link_phy.sv
// self-checking bench for the line layer
`timescale 1ns/1ps
`default_nettype none
module tb_one_wire_debug_link_phy;
  logic clk = 1'h0, rst = 1'h1, we = 1'h0, re = 1'h0, fuse = 1'h0, hv = 1'h0, tx_valid = 1'h0;
  logic exp_sync = 1'h0, store_req = 1'h0, grant = 1'h0, key = 1'h0, mode = 1'h0, rx_q = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, tx_byte = 8'h00, sysinfo = 8'hC5, got_rx = 8'h00;
  logic [7:0] rdata, rx_byte;
  logic pin_out, oe_n, pull_en, in_en, rx_strobe, tx_ready, bus_req, brk, priv, drv_en, drv_bit;
  int mismatches = 0, n_tests = 0, n_rx = 0, n_brk = 0;
  // pull-up wins when nobody drives
  wire line = !oe_n ? pin_out : (drv_en ? drv_bit : 1'h1);
  owd_link_phy dut_u (.REF_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(we),
    .REG_RD(re), .REG_RDATA(rdata), .RST_PIN_FUSE(fuse), .HV_ENABLE(hv), .LINK_PIN_IN(line),
    .LINK_PIN_OUT(pin_out), .LINK_PIN_OE_N(oe_n), .LINK_PULL_EN(pull_en), .LINK_IN_EN(in_en),
    .RX_BYTE(rx_byte), .RX_STROBE(rx_strobe), .TX_BYTE(tx_byte), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .EXPECT_SYNC(exp_sync), .STORE_REQ(store_req), .BUS_REQ(bus_req),
    .BUS_GRANT(grant), .LINK_BREAK(brk), .KEY_MATCH(key), .MODE_OK(mode),
    .PRIV_ACCESS_EN(priv), .SYSTEM_INFO(sysinfo));
  owd_host_model #(.BIT(80)) host_u (.clk(clk), .line(line), .drv_en(drv_en), .drv_bit(drv_bit));
  // ==========
  // clock, event capture, helpers
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // byte lands in got_rx two cycles after its strobe
  always @(posedge clk)
  begin
    if (rx_q) got_rx <= rx_byte;
    rx_q <= rx_strobe;
    if (rx_strobe) n_rx <= n_rx + 1;
    if (brk) n_brk <= n_brk + 1;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'h1;
    @(posedge clk);
    we <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'h1;
    @(posedge clk);
    re <= 1'h0;
    #1;
    chk($sformatf("reg%0h", a), e, rdata);
  endtask
  // ==========
  // scenarios
  task automatic t_basic();
    rchk(4'h1, 8'h03);
    rchk(4'h7, 8'h00);
    chk("pins_off", 8'h00, {6'h0, pull_en, in_en});
    fuse <= 1'h1;
    repeat (6) @(posedge clk);
    chk("pins_on", 8'h03, {6'h0, pull_en, in_en});
    host_u.send(8'h55, 1'h0);
    host_u.send(8'hA3, 1'h0);
    repeat (4) @(posedge clk);
    chk("rx", 8'hA3, got_rx);
    chk("n_rx", 8'h01, 8'(n_rx));
    rchk(4'h3, 8'h03);
  endtask
  // bad parity traps the link, break recovers it and the divider
  task automatic t_err_break();
    host_u.send(8'h01, 1'h1);
    repeat (4) @(posedge clk);
    rchk(4'h2, 8'h11);
    wr_reg(4'h1, 8'h01);
    rchk(4'h1, 8'h01);
    host_u.brk(1200);
    chk("n_brk", 8'h01, 8'(n_brk));
    rchk(4'h1, 8'h03);
    wr_reg(4'h2, 8'h0F);
    rchk(4'h2, 8'h10);
    wr_reg(4'h0, 8'h01);
    host_u.send(8'h55, 1'h0);
    host_u.send(8'h5A, 1'h1);
    repeat (4) @(posedge clk);
    chk("rx_parity_check_disable", 8'h5A, got_rx);
    rchk(4'h2, 8'h10);
    wr_reg(4'h0, 8'h00);
  endtask
  // plain transmit, then a store acknowledged after a slow grant
  task automatic t_tx_ack();
    logic [7:0] d;
    logic ok;
    fork
      host_u.recv(d, ok);
      begin
        @(posedge clk);
        tx_byte <= 8'h3C;
        tx_valid <= 1'h1;
        @(posedge clk);
        tx_valid <= 1'h0;
      end
    join
    chk("tx", 8'h3C, d);
    chk("tx_ok", 8'h01, {7'h0, ok});
    store_req <= 1'h1;
    @(posedge clk);
    store_req <= 1'h0;
    repeat (20) @(posedge clk);
    chk("bus_req", 8'h01, {7'h0, bus_req});
    fork
      host_u.recv(d, ok);
      begin
        grant <= 1'h1;
        @(posedge clk);
        grant <= 1'h0;
      end
    join
    chk("ack", 8'h40, d);
    chk("ack_ok", 8'h01, {7'h0, ok});
    // a new instruction must reopen with a synch before the link is ready
    exp_sync <= 1'h1;
    @(posedge clk);
    exp_sync <= 1'h0;
    repeat (2) @(posedge clk);
    chk("sync_wait", 8'h00, {7'h0, tx_ready});
    host_u.send(8'h55, 1'h0);
    chk("sync_done", 8'h01, {7'h0, tx_ready});
  endtask
  task automatic t_priv();
    key <= 1'h1;
    mode <= 1'h1;
    repeat (3) @(posedge clk);
    chk("priv_on", 8'h01, {7'h0, priv});
    rchk(4'h4, 8'hC5);
    mode <= 1'h0;
    repeat (3) @(posedge clk);
    chk("priv_off", 8'h00, {7'h0, priv});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    t_basic();
    t_err_break();
    t_tx_ack();
    t_priv();
    wrap_up();
  end
  // the run needs about ten thousand cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
